// ==== design/tmrx_pkg.sv ====
// Constants for the timer 0/1 and external interrupt flag block
package tmrx_pkg;
    // Register offsets on the special function register port
    localparam logic [7:0] ADDR_TIMER_AND_IRQ_CONTROL = 8'h88;
    localparam logic [7:0] ADDR_TIMER_MODE_CONTROL = 8'h89;
    localparam logic [7:0] ADDR_TIMER0_LOW = 8'h8A;
    localparam logic [7:0] ADDR_TIMER1_LOW = 8'h8B;
    localparam logic [7:0] ADDR_TIMER0_HIGH = 8'h8C;
    localparam logic [7:0] ADDR_TIMER1_HIGH = 8'h8D;
    localparam logic [7:0] ADDR_COUNT_RATE = 8'hA0;
    localparam logic [7:0] ADDR_INT_STATUS = 8'hA1;
    localparam logic [7:0] ADDR_INT_MASK = 8'hA2;

    // Bit positions in timer_and_irq_control
    localparam int TC_TIMER1_OVERFLOW_FLAG = 7;
    localparam int TC_TIMER1_RUN = 6;
    localparam int TC_TIMER0_OVERFLOW_FLAG = 5;
    localparam int TC_TIMER0_RUN = 4;
    localparam int TC_EXT_IRQ_B_FLAG = 3;
    localparam int TC_EXT_IRQ_B_TYPE = 2;
    localparam int TC_EXT_IRQ_A_FLAG = 1;
    localparam int TC_EXT_IRQ_A_TYPE = 0;

    // Field positions in timer_mode_control, per timer nibble
    localparam int TM_NIBBLE = 4;
    localparam int TM_GATE = 3;
    localparam int TM_COUNTER_SEL = 2;
    localparam int TM_MODE_LSB = 0;

    // Event positions in status, mask and request vectors
    localparam int EV_TIMER0 = 0;
    localparam int EV_EXT_A = 1;
    localparam int EV_TIMER1 = 2;
    localparam int EV_EXT_B = 3;
    localparam int EV_COUNT = 4;

    // Reset values
    localparam logic [7:0] RST_CONTROL = 8'h00;
    localparam logic [7:0] RST_MODE = 8'h00;
    localparam logic [7:0] RST_COUNT = 8'h00;
    localparam logic RST_RATE_FAST = 1'b0;

    // Cycles per count tick in timer mode
    localparam logic [3:0] DIV_FAST = 4'h4;
    localparam logic [3:0] DIV_LEGACY = 4'hC;

    // Timer operating modes
    typedef enum logic [1:0] {
        TMRX_MODE_13BIT = 2'h0,
        TMRX_MODE_16BIT = 2'h1,
        TMRX_MODE_RELOAD8 = 2'h2,
        TMRX_MODE_SPLIT8 = 2'h3
    } tmrx_mode_e;
endpackage

// ==== design/tmrx_timer01.sv ====
// Timer/counter 0 and 1 with external interrupt A/B flag logic
// Functional notes
// RULE_01 - Tick every 4 or 12 clocks, selectable
// RULE_02 - Two 16-bit count registers, classic behaviour
// RULE_03 - Timer 1 overflow sets its flag
// RULE_04 - Timer 1 flag: vector clears, software writes
// RULE_05 - Timer 0 overflow sets its flag
// RULE_06 - Timer 0 flag: vector clears, software writes
// RULE_07 - Run bit starts and stops each timer
// RULE_08 - Pin B condition sets external flag B
// RULE_09 - Pin A condition sets external flag A
// RULE_10 - Vector clears edge flags; level follows pin
// RULE_11 - Type bit picks falling edge or low level
// RULE_12 - Gate set: count only while pin high
// RULE_13 - Gate clear: run bit alone enables counting
// RULE_14 - Counter select: count falling count pin edges
// RULE_15 - Count and interrupt pins on port 3
// RULE_16 - Type one is edge, zero is level
// RULE_17 - Four modes: 13, 16, reload 8, split
// RULE_18 - Flags request interrupts; acknowledge clears them (code: level-mode external flags follow the pin, acknowledge leaves them)
`timescale 1ns/100ps
module tmrx_timer01
    import tmrx_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    input wire logic timer0_count_pin,
    input wire logic timer1_count_pin,
    input wire logic external_irq_a_pin,
    input wire logic external_irq_b_pin,
    input wire logic [EV_COUNT-1:0] vector_ack,
    output logic [EV_COUNT-1:0] irq_req,
    output logic irq
);
    // Whole block state
    typedef struct packed {
        logic [7:0] control;
        logic [7:0] mode;
        logic [7:0] tl0;
        logic [7:0] th0;
        logic [7:0] tl1;
        logic [7:0] th1;
        logic rate_fast;
        logic [3:0] presc;
        logic [3:0] pin_prev;
        logic [EV_COUNT-1:0] status;
        logic [EV_COUNT-1:0] mask;
        logic [7:0] rdata;
    } tmrx_state_s;

    tmrx_state_s state_reg;
    tmrx_state_s state_next;

    // Elaboration checks on the shared constants
    if (DIV_FAST == 4'h0 || DIV_LEGACY == 4'h0) begin : g_div_zero
        $error("count rate divider of zero");
    end
    if (DIV_FAST >= DIV_LEGACY) begin : g_div_order
        $error("fast count rate not faster than legacy rate");
    end
    if (EV_COUNT > 8) begin : g_ev_wide
        $error("event vector wider than a register byte");
    end
    if (EV_TIMER0 >= EV_COUNT || EV_TIMER1 >= EV_COUNT ||
        EV_EXT_A >= EV_COUNT || EV_EXT_B >= EV_COUNT) begin : g_ev_pos
        $error("event position outside the event vector");
    end
    if (TM_NIBBLE + TM_GATE > 7 ||
        TM_NIBBLE + TM_MODE_LSB + 1 > 7) begin : g_mode_field
        $error("mode field outside the mode register");
    end
    if (TC_TIMER1_OVERFLOW_FLAG > 7 || TC_EXT_IRQ_B_FLAG > 7) begin : g_ctl
        $error("control field outside the control register");
    end
    if (ADDR_TIMER_AND_IRQ_CONTROL == ADDR_TIMER_MODE_CONTROL) begin : g_addr
        $error("control and mode registers share an address");
    end

    // One count step for a given mode: {overflow, th, tl}
    function automatic logic [16:0] tmrx_step(input logic [1:0] md,
                                              input logic [7:0] tl,
                                              input logic [7:0] th);
        logic [16:0] res;
        logic [15:0] sum;
        res = {1'b0, th, tl};
        sum = 16'h0000;
        unique case (tmrx_mode_e'(md))
            TMRX_MODE_13BIT: begin
                if (tl[4:0] == 5'h1F) begin
                    res = {(th == 8'hFF), th + 8'h01, tl[7:5], 5'h00};
                end else begin
                    res = {1'b0, th, tl[7:5], tl[4:0] + 5'h01};
                end
            end
            TMRX_MODE_16BIT: begin
                sum = {th, tl} + 16'h0001;
                res = {({th, tl} == 16'hFFFF), sum};
            end
            TMRX_MODE_RELOAD8: begin
                if (tl == 8'hFF) begin
                    res = {1'b1, th, th};
                end else begin
                    res = {1'b0, th, tl + 8'h01};
                end
            end
            TMRX_MODE_SPLIT8: begin
                res = {(tl == 8'hFF), th, tl + 8'h01};
            end
        endcase
        return res;
    endfunction

    // Next external flag: edge mode sticks until vectored, level follows
    function automatic logic tmrx_ext_next(input logic edge_mode,
                                           input logic flag,
                                           input logic hit,
                                           input logic ack_ok);
        logic res;
        res = flag;
        if (edge_mode) begin
            if (ack_ok) begin
                res = 1'b0; // RULE_10
            end
            if (hit) begin
                res = 1'b1;
            end
        end else begin
            res = hit; // RULE_10
        end
        return res;
    endfunction

    // Widen an event vector to a register byte
    function automatic logic [7:0] tmrx_pad(input logic [EV_COUNT-1:0] v);
        logic [7:0] res;
        res = 8'h00;
        res[EV_COUNT-1:0] = v;
        return res;
    endfunction

    // Pin vector in pin_prev order: t0, t1, int A, int B
    logic [3:0] pins;
    assign pins = {external_irq_b_pin, external_irq_a_pin,
                   timer1_count_pin, timer0_count_pin}; // RULE_15

    // Combinational next state
    always_comb begin
        // Tick and pin edges
        logic tick;
        logic [3:0] falls;
        logic [3:0] div;

        // Timer enables
        logic [1:0] md0;
        logic [1:0] md1;
        logic run0;
        logic run1;
        logic en0;
        logic en1;
        logic en_th0;

        // Count results
        logic ovf0;
        logic ovf1;
        logic [16:0] st0;
        logic [16:0] st1;
        logic [7:0] th0_inc;

        // Flag sets and write decode
        logic set_tf0;
        logic set_tf1;
        logic set_ea;
        logic set_eb;
        logic wr_ctl;

        // Status events and write-one clears
        logic [EV_COUNT-1:0] events;
        logic [EV_COUNT-1:0] w1c;

        state_next = state_reg;
        tick = 1'b0;
        falls = state_reg.pin_prev & ~pins;
        md0 = state_reg.mode[TM_MODE_LSB +: 2];
        md1 = state_reg.mode[TM_NIBBLE + TM_MODE_LSB +: 2];
        wr_ctl = reg_write && (reg_addr == ADDR_TIMER_AND_IRQ_CONTROL);
        th0_inc = state_reg.th0 + 8'h01;
        events = '0;
        w1c = '0;

        // Defaults for the working values
        div = DIV_LEGACY;
        run0 = 1'b0;
        run1 = 1'b0;
        en0 = 1'b0;
        en1 = 1'b0;
        en_th0 = 1'b0;
        ovf0 = 1'b0;
        ovf1 = 1'b0;
        st0 = '0;
        st1 = '0;
        set_tf0 = 1'b0;
        set_tf1 = 1'b0;
        set_ea = 1'b0;
        set_eb = 1'b0;

        // Prescaler: one tick every 4 or 12 clocks
        div = state_reg.rate_fast ? DIV_FAST : DIV_LEGACY; // RULE_01
        if (state_reg.presc >= div - 4'h1) begin
            state_next.presc = 4'h0;
            tick = 1'b1; // RULE_01
        end else begin
            state_next.presc = state_reg.presc + 4'h1;
        end
        state_next.pin_prev = pins;

        // Run and gate; gate needs the interrupt pin high
        run0 = state_reg.control[TC_TIMER0_RUN] && // RULE_07
               (!state_reg.mode[TM_GATE] || external_irq_a_pin); // RULE_12
        run1 = state_reg.control[TC_TIMER1_RUN] && // RULE_07
               (!state_reg.mode[TM_NIBBLE + TM_GATE] || // RULE_13
                external_irq_b_pin); // RULE_12
        // Source: internal tick or falling count pin edge
        en0 = run0 && (state_reg.mode[TM_COUNTER_SEL] ? falls[0]
                                                      : tick); // RULE_14
        en1 = run1 && (state_reg.mode[TM_NIBBLE + TM_COUNTER_SEL] ?
                       falls[1] : tick); // RULE_14
        // Split mode: high byte of timer 0 runs off timer 1 run bit
        en_th0 = (tmrx_mode_e'(md0) == TMRX_MODE_SPLIT8) &&
                 state_reg.control[TC_TIMER1_RUN] && tick; // RULE_17
        // Timer 1 in split mode simply holds
        if (tmrx_mode_e'(md1) == TMRX_MODE_SPLIT8) begin
            en1 = 1'b0; // RULE_17
        end

        // Count steps
        st0 = tmrx_step(md0, state_reg.tl0, state_reg.th0); // RULE_17
        st1 = tmrx_step(md1, state_reg.tl1, state_reg.th1); // RULE_02
        ovf0 = en0 && st0[16];
        ovf1 = en1 && st1[16];
        if (en0) begin
            state_next.th0 = st0[15:8];
            state_next.tl0 = st0[7:0];
        end
        if (en_th0) begin
            state_next.th0 = th0_inc;
        end
        if (en1) begin
            state_next.th1 = st1[15:8];
            state_next.tl1 = st1[7:0];
        end
        set_tf0 = ovf0; // RULE_05
        if (tmrx_mode_e'(md0) == TMRX_MODE_SPLIT8) begin
            set_tf1 = en_th0 && (state_reg.th0 == 8'hFF);
        end else begin
            set_tf1 = ovf1; // RULE_03
        end

        // External conditions: type 1 falling edge, type 0 low level
        set_ea = state_reg.control[TC_EXT_IRQ_A_TYPE] ? falls[2]
                                                      : !pins[2]; // RULE_16
        set_eb = state_reg.control[TC_EXT_IRQ_B_TYPE] ? falls[3]
                                                      : !pins[3]; // RULE_11

        // Software writes to control come first
        if (wr_ctl) begin
            state_next.control = reg_wdata; // RULE_07
        end

        // Timer flags: set beats any clear
        if (!wr_ctl && vector_ack[EV_TIMER0]) begin
            state_next.control[TC_TIMER0_OVERFLOW_FLAG] = 1'b0; // RULE_06
        end
        if (set_tf0) begin
            state_next.control[TC_TIMER0_OVERFLOW_FLAG] = 1'b1; // RULE_05
        end
        if (!wr_ctl && vector_ack[EV_TIMER1]) begin
            state_next.control[TC_TIMER1_OVERFLOW_FLAG] = 1'b0; // RULE_04
        end
        if (set_tf1) begin
            state_next.control[TC_TIMER1_OVERFLOW_FLAG] = 1'b1; // RULE_03
        end

        // External flag A: edge mode clears on vector, level follows pin
        state_next.control[TC_EXT_IRQ_A_FLAG] = tmrx_ext_next(
            state_reg.control[TC_EXT_IRQ_A_TYPE],
            state_next.control[TC_EXT_IRQ_A_FLAG], set_ea,
            !wr_ctl && vector_ack[EV_EXT_A]); // RULE_09
        // External flag B, same scheme
        state_next.control[TC_EXT_IRQ_B_FLAG] = tmrx_ext_next(
            state_reg.control[TC_EXT_IRQ_B_TYPE],
            state_next.control[TC_EXT_IRQ_B_FLAG], set_eb,
            !wr_ctl && vector_ack[EV_EXT_B]); // RULE_08

        // Register writes other than control; write beats counting
        if (reg_write) begin
            unique case (reg_addr)
                ADDR_TIMER_MODE_CONTROL: state_next.mode = reg_wdata;
                ADDR_TIMER0_LOW: state_next.tl0 = reg_wdata;
                ADDR_TIMER0_HIGH: state_next.th0 = reg_wdata;
                ADDR_TIMER1_LOW: state_next.tl1 = reg_wdata;
                ADDR_TIMER1_HIGH: state_next.th1 = reg_wdata;
                ADDR_COUNT_RATE: state_next.rate_fast = reg_wdata[0];
                ADDR_INT_STATUS: w1c = reg_wdata[EV_COUNT-1:0];
                ADDR_INT_MASK: state_next.mask = reg_wdata[EV_COUNT-1:0];
                default: ;
            endcase
        end

        // Sticky status: hardware set beats write-one clear
        events[EV_TIMER0] = set_tf0;
        events[EV_TIMER1] = set_tf1;
        events[EV_EXT_A] = state_next.control[TC_EXT_IRQ_A_FLAG] &&
                           !state_reg.control[TC_EXT_IRQ_A_FLAG];
        events[EV_EXT_B] = state_next.control[TC_EXT_IRQ_B_FLAG] &&
                           !state_reg.control[TC_EXT_IRQ_B_FLAG];
        state_next.status = (state_reg.status & ~w1c) | events;

        // Read data, valid only in the cycle after the strobe
        state_next.rdata = 8'h00;
        if (reg_read) begin
            unique case (reg_addr)
                ADDR_TIMER_AND_IRQ_CONTROL: state_next.rdata =
                    state_reg.control;
                ADDR_TIMER_MODE_CONTROL: state_next.rdata = state_reg.mode;
                ADDR_TIMER0_LOW: state_next.rdata = state_reg.tl0;
                ADDR_TIMER0_HIGH: state_next.rdata = state_reg.th0;
                ADDR_TIMER1_LOW: state_next.rdata = state_reg.tl1;
                ADDR_TIMER1_HIGH: state_next.rdata = state_reg.th1;
                ADDR_COUNT_RATE: state_next.rdata =
                    {7'h00, state_reg.rate_fast};
                ADDR_INT_STATUS: state_next.rdata =
                    tmrx_pad(state_reg.status);
                ADDR_INT_MASK: state_next.rdata =
                    tmrx_pad(state_reg.mask);
                default: state_next.rdata = 8'h00;
            endcase
        end
    end

    // State register
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg.control <= RST_CONTROL;
            state_reg.mode <= RST_MODE;
            state_reg.tl0 <= RST_COUNT;
            state_reg.th0 <= RST_COUNT;
            state_reg.tl1 <= RST_COUNT;
            state_reg.th1 <= RST_COUNT;
            state_reg.rate_fast <= RST_RATE_FAST;
            state_reg.presc <= 4'h0;
            state_reg.pin_prev <= 4'hF;
            state_reg.status <= '0;
            state_reg.mask <= '0;
            state_reg.rdata <= 8'h00;
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs: per-source requests and masked summary interrupt
    assign reg_rdata = state_reg.rdata;
    assign irq_req[EV_TIMER0] =
        state_reg.control[TC_TIMER0_OVERFLOW_FLAG]; // RULE_18
    assign irq_req[EV_TIMER1] = state_reg.control[TC_TIMER1_OVERFLOW_FLAG];
    assign irq_req[EV_EXT_A] = state_reg.control[TC_EXT_IRQ_A_FLAG];
    assign irq_req[EV_EXT_B] = state_reg.control[TC_EXT_IRQ_B_FLAG];
    // Summary interrupt: any unmasked sticky status bit
    assign irq = |(state_reg.status & state_reg.mask);
endmodule // tmrx_timer01

// ==== verif/tb_top.sv ====
// Self-checking bench for the timer 0/1 block
`timescale 1ns/100ps
module tb_top;
    import tmrx_pkg::*;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [7:0] reg_rdata;
    logic [3:0] vector_ack = 4'h0;
    logic [3:0] irq_req;
    logic irq;
    logic [3:0] pin_low = 4'h0;
    logic pa;
    logic pb;
    logic p0;
    logic p1;
    int error_cnt = 0;
    int comparisons = 0;
    int n;
    logic [7:0] v;
    logic [7:0] u;
    logic [7:0] rows [0:5][0:2] = '{'{8'h89, 8'h5A, 8'h5A},
        '{8'h8A, 8'h12, 8'h12}, '{8'h8B, 8'h34, 8'h34},
        '{8'h8C, 8'h56, 8'h56}, '{8'h8D, 8'h78, 8'h78},
        '{8'h55, 8'hFF, 8'h00}};
    localparam logic [7:0] CTL = ADDR_TIMER_AND_IRQ_CONTROL;

    // Clock at 10 MHz
    always #50 core_clk = ~core_clk;

    tmrx_pins_model u_tmrx_pins_model (.pin_low(pin_low),
        .external_irq_a_pin(pa), .external_irq_b_pin(pb),
        .timer0_count_pin(p0), .timer1_count_pin(p1));
    tmrx_timer01 u_tmrx_timer01 (.core_clk(core_clk), .reset_n(reset_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata), .timer0_count_pin(p0),
        .timer1_count_pin(p1), .external_irq_a_pin(pa),
        .external_irq_b_pin(pb), .vector_ack(vector_ack),
        .irq_req(irq_req), .irq(irq));

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge core_clk);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge core_clk);
        reg_read <= 1'b0;
        @(negedge core_clk);
        d = reg_rdata;
    endtask
    task automatic ack(input int i);
        @(posedge core_clk);
        vector_ack[i] <= 1'b1;
        @(posedge core_clk);
        vector_ack[i] <= 1'b0;
        #1;
    endtask
    task automatic wait_req(input int i, input logic val);
        n = 0;
        while (irq_req[i] !== val) begin
            @(posedge core_clk);
            #1;
            n++;
            if (n > 2000) begin
                error_cnt++;
                $display("MISMATCH t=%0t got=%h exp=%h", $time, irq_req, val);
                wrap_up();
            end
        end
    endtask
    // Cycles between two overflows of timer 0
    task automatic measure(output int gap);
        ack(EV_TIMER0);
        wait_req(EV_TIMER0, 1'b1);
        ack(EV_TIMER0);
        gap = 2;
        while (irq_req[EV_TIMER0] !== 1'b1 && gap < 100) begin
            @(posedge core_clk);
            #1;
            gap++;
        end
    endtask
    task automatic wrap_up();
        $display("Comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (6) @(posedge core_clk);
        reset_n <= 1'b1;
        foreach (rows[i]) begin
            wr(rows[i][0], rows[i][1]);
            rd(rows[i][0], v);
            chk(v, rows[i][2]);
        end
        $display("Test register rows done");
        @(posedge core_clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        reset_n <= 1'b1;
        for (int a = 8'h88; a <= 8'h8D; a++) begin
            rd(8'(a), v);
            chk(v, 8'h00);
        end
        $display("Test reset values done");
        wr(ADDR_TIMER_MODE_CONTROL, 8'h02);
        wr(ADDR_TIMER0_HIGH, 8'hFF);
        wr(ADDR_TIMER0_LOW, 8'hFF);
        wr(ADDR_INT_MASK, 8'h01);
        wr(CTL, 8'h10);
        measure(n);
        chk(8'(n), {4'h0, DIV_LEGACY});
        chk({7'h00, irq}, 8'h01);
        rd(ADDR_INT_STATUS, v);
        chk(v, 8'h01);
        wr(ADDR_COUNT_RATE, 8'h01);
        measure(n);
        chk(8'(n), {4'h0, DIV_FAST});
        wr(CTL, 8'h00);
        wr(ADDR_INT_STATUS, 8'h0F);
        rd(ADDR_INT_STATUS, v);
        chk(v, 8'h00);
        chk({7'h00, irq}, 8'h00);
        $display("Test count rate done");
        wr(CTL, 8'h05);
        pin_low[1:0] <= 2'h3;
        repeat (3) @(posedge core_clk);
        rd(CTL, v);
        chk(v, 8'h0F);
        ack(EV_EXT_A);
        rd(CTL, v);
        chk(v, 8'h0D);
        $display("Test edge flags done");
        wr(ADDR_TIMER_MODE_CONTROL, 8'h90);
        wr(ADDR_TIMER1_LOW, 8'hFF);
        wr(ADDR_TIMER1_HIGH, 8'hFF);
        wr(CTL, 8'h41);
        repeat (40) @(posedge core_clk);
        #1;
        chk({4'h0, irq_req}, 8'h08);
        rd(ADDR_TIMER1_LOW, v);
        chk(v, 8'hFF);
        @(posedge core_clk);
        pin_low[1] <= 1'b0;
        wait_req(EV_TIMER1, 1'b1);
        chk({7'h00, irq_req[EV_EXT_B]}, 8'h00);
        ack(EV_TIMER1);
        chk({7'h00, irq_req[EV_TIMER1]}, 8'h00);
        wr(CTL, 8'h01);
        rd(ADDR_TIMER1_LOW, v);
        repeat (20) @(posedge core_clk);
        rd(ADDR_TIMER1_LOW, u);
        chk(u, v);
        wr(ADDR_TIMER_MODE_CONTROL, 8'h10);
        pin_low[1] <= 1'b1;
        wr(CTL, 8'h41);
        repeat (20) @(posedge core_clk);
        rd(ADDR_TIMER1_LOW, u);
        chk({7'h00, u !== v}, 8'h01);
        $display("Test gating done");
        wr(CTL, 8'h00);
        wr(ADDR_TIMER_MODE_CONTROL, 8'h05);
        wr(ADDR_TIMER0_LOW, 8'h00);
        wr(CTL, 8'h10);
        for (int k = 0; k < 6; k++) begin
            @(posedge core_clk);
            pin_low[2] <= ~pin_low[2];
            @(posedge core_clk);
        end
        rd(ADDR_TIMER0_LOW, v);
        chk(v, 8'h03);
        $display("Test counter mode done");
        wrap_up();
    end
endmodule // tb_top

// ==== verif/tmrx_pins_model.sv ====
// Pull-up pin model for the count and interrupt inputs
`timescale 1ns/100ps
module tmrx_pins_model (
    input wire logic [3:0] pin_low,
    output logic external_irq_a_pin,
    output logic external_irq_b_pin,
    output logic timer0_count_pin,
    output logic timer1_count_pin
);
    // Released pins float high on the port pull-ups
    assign external_irq_a_pin = !pin_low[0];
    assign external_irq_b_pin = !pin_low[1];
    assign timer0_count_pin = !pin_low[2];
    assign timer1_count_pin = !pin_low[3];
endmodule // tmrx_pins_model

// ==== verif/tmrx_timer01_chk.sv ====
// Port-level timing checks for the timer 0/1 block
`timescale 1ns/100ps
module tmrx_timer01_chk
    import tmrx_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic external_irq_a_pin,
    input wire logic external_irq_b_pin,
    input wire logic [EV_COUNT-1:0] vector_ack,
    input wire logic [EV_COUNT-1:0] irq_req,
    input wire logic irq
);
    logic ctl_wr;
    logic type_a_reg;
    logic type_b_reg;
    logic mask_zero_reg;
    assign ctl_wr = reg_write && (reg_addr == ADDR_TIMER_AND_IRQ_CONTROL);
    // Shadow of the software type bits and mask
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            type_a_reg <= 1'b0;
            type_b_reg <= 1'b0;
            mask_zero_reg <= 1'b1;
        end else begin
            if (ctl_wr) begin
                type_a_reg <= reg_wdata[TC_EXT_IRQ_A_TYPE];
                type_b_reg <= reg_wdata[TC_EXT_IRQ_B_TYPE];
            end
            if (reg_write && reg_addr == ADDR_INT_MASK) begin
                mask_zero_reg <= (reg_wdata[EV_COUNT-1:0] == 4'h0);
            end
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    level_a_a: assert property ($past(reset_n) && !$past(type_a_reg)
        && !$past(ctl_wr) && !$past(vector_ack[EV_EXT_A])
        |-> irq_req[EV_EXT_A] == !$past(external_irq_a_pin))
        else $error("ext A level flag wrong");
    level_b_a: assert property ($past(reset_n) && !$past(type_b_reg)
        && !$past(ctl_wr) && !$past(vector_ack[EV_EXT_B])
        |-> irq_req[EV_EXT_B] == !$past(external_irq_b_pin))
        else $error("ext B level flag wrong");
    edge_a_set_a: assert property ($past(type_a_reg)
        && $past(external_irq_a_pin, 2) && !$past(external_irq_a_pin)
        |-> irq_req[EV_EXT_A]) else $error("ext A edge missed");
    edge_b_set_a: assert property ($past(type_b_reg)
        && $past(external_irq_b_pin, 2) && !$past(external_irq_b_pin)
        |-> irq_req[EV_EXT_B]) else $error("ext B edge missed");
    edge_a_clr_a: assert property ($past(type_a_reg)
        && $past(vector_ack[EV_EXT_A]) && !$past(ctl_wr)
        && !($past(external_irq_a_pin, 2) && !$past(external_irq_a_pin))
        |-> !irq_req[EV_EXT_A]) else $error("ext A ack ignored");
    tf0_fall_a: assert property ($fell(irq_req[EV_TIMER0])
        |-> $past(vector_ack[EV_TIMER0]) || $past(ctl_wr))
        else $error("timer 0 flag lost");
    tf1_fall_a: assert property ($fell(irq_req[EV_TIMER1])
        |-> $past(vector_ack[EV_TIMER1]) || $past(ctl_wr))
        else $error("timer 1 flag lost");
    mask_quiet_a: assert property (mask_zero_reg
        && $past(mask_zero_reg) |-> !irq) else $error("masked irq high");
endmodule // tmrx_timer01_chk

bind tmrx_timer01 tmrx_timer01_chk u_chk (.core_clk(core_clk),
    .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .external_irq_a_pin(external_irq_a_pin),
    .external_irq_b_pin(external_irq_b_pin), .vector_ack(vector_ack),
    .irq_req(irq_req), .irq(irq));
